// [design/ipc_consts.svh]
// Offsets, field positions, reset values and sizes of the interrupt controller
`ifndef IPC_CONSTS_SVH
`define IPC_CONSTS_SVH
`define IPC_AW 8
`define IPC_NSRC 8
`define IPC_NEXT 3
`define IPC_NPER 5
`define IPC_NTRAP 4
`define IPC_DEPTH 16
`define IPC_DEPTH_W 5
`define IPC_TD_W 14
`define IPC_NEVT 3
`define IPC_OFF_NTC 8'h00
`define IPC_OFF_EVC 8'h04
`define IPC_OFF_FLAG 8'h08
`define IPC_OFF_ENA 8'h0C
`define IPC_OFF_PRIO 8'h10
`define IPC_OFF_CPU 8'h14
`define IPC_OFF_TDIS 8'h18
`define IPC_OFF_ISTAT 8'h1C
`define IPC_OFF_ICLR 8'h20
`define IPC_OFF_IENA 8'h24
`define IPC_BIT_NESTDIS 15
`define IPC_BIT_ALT 15
`define IPC_BIT_TDACT 14
`define IPC_CPU_LSB 5
`define IPC_PRIO_RST 24'h924924
`define IPC_USER_MAX 4'h7
`define IPC_TD_TOP 3'h7
`define IPC_TRAP_BASE 4'h8
`define IPC_USER_VEC 5'h08
`define IPC_STD_BASE 16'h0004
`define IPC_ALT_BASE 16'h0104
`define IPC_RESP_OK 2'h0
`define IPC_RESP_ERR 2'h2
`define IPC_EVT_ACCEPT 0
`define IPC_EVT_TRAP 1
`define IPC_EVT_RETURN 2
`endif

// [design/ipc_pkg.sv]
// Types shared by the interrupt controller files
`include "ipc_consts.svh"
package ipc_pkg;
  typedef struct packed {
    logic awvalid;
    logic [`IPC_AW-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`IPC_AW-1:0] araddr;
    logic rready;
  } ipc_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ipc_axi_rsp_s;

  typedef struct packed {
    logic [`IPC_NEXT-1:0] prevPin;
    logic [`IPC_NEXT-1:0] pulse;
  } ipc_edge_s;

  typedef struct packed {
    logic awHeld;
    logic [`IPC_AW-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic nestDis;
    logic [`IPC_NTRAP-1:0] trapFlags;
    logic altTable;
    logic [`IPC_NEXT-1:0] polarity;
    logic [`IPC_NSRC-1:0] flags;
    logic [`IPC_NSRC-1:0] enable;
    logic [3*`IPC_NSRC-1:0] prio;
    logic [3:0] cpuPri;
    logic [`IPC_TD_W-1:0] tdCount;
    logic [`IPC_NEVT-1:0] intStatus;
    logic [`IPC_NEVT-1:0] intEnable;
    logic reqValid;
    logic reqTrap;
    logic [4:0] reqNum;
    logic [3:0] reqLevel;
    logic [15:0] vector;
    logic [`IPC_DEPTH_W-1:0] depth;
    logic [`IPC_DEPTH-1:0][32:0] stack;
    logic [23:0] retPc;
    logic [7:0] retSrl;
  } ipc_state_s;
endpackage : ipc_pkg

// [design/ipc_edge_detect.sv]
// Polarity-selectable edge detector for the external interrupt pins
`timescale 1ns/1ps
`include "ipc_consts.svh"
module ipc_edge_detect (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [`IPC_NEXT-1:0] extPin,
  input wire logic [`IPC_NEXT-1:0] polarity,
  output logic [`IPC_NEXT-1:0] edgePulse
);
  ipc_pkg::ipc_edge_s s;
  ipc_pkg::ipc_edge_s next_s;
  logic [`IPC_NEXT-1:0] hit;

  // ----------------------------------------
  // Edge select per pin
  // ----------------------------------------
  for (genvar i = 0; i < `IPC_NEXT; i++) begin : g_pin
    assign hit[i] = polarity[i] ? (s.prevPin[i] & ~extPin[i]) : (~s.prevPin[i] & extPin[i]);
  end

  always_comb begin
    next_s = s;
    next_s.prevPin = extPin;
    next_s.pulse = hit;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s <= '0;
      // Track the pin through reset so its idle level gives no false edge
      s.prevPin <= extPin;
    end else begin
      s <= next_s;
    end
  end

  assign edgePulse = s.pulse;

  fall_edge_a: assert property (@(posedge sys_clk) disable iff (reset)
    polarity[0] && $past(polarity[0]) && $fell(extPin[0]) |=> edgePulse[0])
    else $error("falling edge on pin 0 not detected");
endmodule : ipc_edge_detect

// [design/ipc_controller.sv]
// Priority interrupt controller with AXI4-Lite register access
`timescale 1ns/1ps
`include "ipc_consts.svh"
module ipc_controller (
  input wire logic sys_clk,
  input wire logic reset,
  input wire ipc_pkg::ipc_axi_req_s axiReq,
  output ipc_pkg::ipc_axi_rsp_s axiRsp,
  input wire logic [`IPC_NEXT-1:0] extPin,
  input wire logic [`IPC_NPER-1:0] periphReq,
  input wire logic [`IPC_NTRAP-1:0] trapReq,
  input wire logic instrTick,
  output logic irqReq,
  output logic [15:0] irqVector,
  output logic [3:0] irqLevel,
  input wire logic irqAck,
  input wire logic [23:0] pcIn,
  input wire logic [7:0] statusLowIn,
  input wire logic returnFromInterrupt,
  output logic [23:0] retPc,
  output logic [7:0] retStatusLow,
  output logic [3:0] cpuPriority,
  output logic intr
);
  ipc_pkg::ipc_state_s s;
  ipc_pkg::ipc_state_s next_s;
  logic [`IPC_NEXT-1:0] edgePulse;
  logic [`IPC_NSRC-1:0] srcSet;
  logic [`IPC_NSRC-1:0] pending;
  logic wrEn;
  logic rdEn;
  logic [31:0] wrVal;
  logic [31:0] rdVal;
  logic rdHit;
  logic wrHit;
  logic [2:0] bestP;
  logic [2:0] bestIdx;
  logic bestHit;
  logic [1:0] trapIdx;
  logic trapHit;
  logic [2:0] effP;
  logic [3:0] candLevel;
  logic [4:0] candNum;
  logic candTrap;
  logic candOk;
  logic tdActive;
  logic ackTake;
  logic retTake;
  logic [`IPC_NEVT-1:0] evt;
  logic [31:0] mrg;

  function automatic logic [31:0] ipc_merge(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b+:8] = d[8*b+:8];
      end
    end
    return m;
  endfunction : ipc_merge

  ipc_edge_detect u_edge (
    .sys_clk(sys_clk),
    .reset(reset),
    .extPin(extPin),
    .polarity(s.polarity),
    .edgePulse(edgePulse)
  );

  assign srcSet = {periphReq, edgePulse};
  assign pending = s.flags & s.enable;
  assign tdActive = (s.tdCount != '0);
  assign ackTake = irqAck & s.reqValid;
  assign retTake = returnFromInterrupt & (s.depth != '0);

  // ----------------------------------------
  // Register read and write decode
  // ----------------------------------------
  assign wrEn = s.awHeld & s.wHeld & ~s.bvalid;
  assign rdEn = axiReq.arvalid & ~s.rvalid;

  always_comb begin
    rdHit = 1'b1;
    rdVal = '0;
    case (axiReq.araddr)
      `IPC_OFF_NTC: begin
        rdVal[`IPC_BIT_NESTDIS] = s.nestDis;
        rdVal[`IPC_NTRAP-1:0] = s.trapFlags;
      end
      `IPC_OFF_EVC: begin
        rdVal[`IPC_BIT_ALT] = s.altTable;
        rdVal[`IPC_BIT_TDACT] = tdActive;
        rdVal[`IPC_NEXT-1:0] = s.polarity;
      end
      `IPC_OFF_FLAG: rdVal[`IPC_NSRC-1:0] = s.flags;
      `IPC_OFF_ENA: rdVal[`IPC_NSRC-1:0] = s.enable;
      `IPC_OFF_PRIO: rdVal[3*`IPC_NSRC-1:0] = s.prio;
      `IPC_OFF_CPU: rdVal[`IPC_CPU_LSB+:4] = s.cpuPri;
      `IPC_OFF_TDIS: rdVal[`IPC_TD_W-1:0] = s.tdCount;
      `IPC_OFF_ISTAT: rdVal[`IPC_NEVT-1:0] = s.intStatus;
      `IPC_OFF_ICLR: rdVal = '0;
      `IPC_OFF_IENA: rdVal[`IPC_NEVT-1:0] = s.intEnable;
      default: rdHit = 1'b0;
    endcase
  end

  always_comb begin
    wrHit = 1'b1;
    wrVal = '0;
    case (s.awAddr)
      `IPC_OFF_NTC, `IPC_OFF_EVC, `IPC_OFF_FLAG, `IPC_OFF_ENA, `IPC_OFF_PRIO, `IPC_OFF_CPU,
      `IPC_OFF_TDIS, `IPC_OFF_ICLR, `IPC_OFF_IENA: wrVal = s.wData;
      `IPC_OFF_ISTAT: wrVal = '0;
      default: wrHit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Arbitration
  // ----------------------------------------
  always_comb begin
    bestP = '0;
    bestIdx = '0;
    bestHit = 1'b0;
    effP = '0;
    // Scan downward so an equal priority later in the scan wins: lowest index
    for (int i = `IPC_NSRC-1; i >= 0; i--) begin
      effP = s.prio[3*i+:3];
      if (tdActive && effP != `IPC_TD_TOP) begin
        effP = '0;
      end
      if (pending[i] && effP != '0 && effP >= bestP) begin
        bestP = effP;
        bestIdx = 3'(i);
        bestHit = 1'b1;
      end
    end
    trapHit = 1'b0;
    trapIdx = '0;
    for (int t = 0; t < `IPC_NTRAP; t++) begin
      if (s.trapFlags[t]) begin
        trapHit = 1'b1;
        trapIdx = 2'(t);
      end
    end
    candTrap = 1'b0;
    candLevel = {1'b0, bestP};
    candNum = `IPC_USER_VEC + {2'h0, bestIdx};
    // Traps outrank every user level, so no CPU priority below 8 masks them
    candOk = bestHit && (candLevel > s.cpuPri) && !(s.nestDis && s.depth != '0);
    if (trapHit && ((`IPC_TRAP_BASE + {2'h0, trapIdx}) > s.cpuPri)) begin
      candTrap = 1'b1;
      candLevel = `IPC_TRAP_BASE + {2'h0, trapIdx};
      candNum = {3'h0, trapIdx};
      candOk = 1'b1;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    evt = '0;
    mrg = '0;
    // Bus channels
    if (axiReq.awvalid && !s.awHeld && !s.bvalid) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && !s.wHeld && !s.bvalid) begin
      next_s.wHeld = 1'b1;
      next_s.wData = axiReq.wdata;
      next_s.wStrb = axiReq.wstrb;
    end
    if (s.bvalid && axiReq.bready) begin
      next_s.bvalid = 1'b0;
    end
    if (wrEn) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = wrHit ? `IPC_RESP_OK : `IPC_RESP_ERR;
    end
    if (s.rvalid && axiReq.rready) begin
      next_s.rvalid = 1'b0;
    end
    if (rdEn) begin
      next_s.rvalid = 1'b1;
      next_s.rdata = rdVal;
      next_s.rresp = rdHit ? `IPC_RESP_OK : `IPC_RESP_ERR;
    end
    // Timed disable counts instruction cycles
    if (instrTick && tdActive) begin
      next_s.tdCount = s.tdCount - 1'b1;
    end
    // Register writes, merged by byte lane except the ICLR write, which ignores the strobes
    if (wrEn && wrHit) begin
      case (s.awAddr)
        `IPC_OFF_NTC: begin
          mrg = ipc_merge({16'h0, s.nestDis, 11'h0, s.trapFlags}, wrVal, s.wStrb);
          next_s.nestDis = mrg[`IPC_BIT_NESTDIS];
          next_s.trapFlags = s.trapFlags & mrg[`IPC_NTRAP-1:0];
        end
        `IPC_OFF_EVC: begin
          mrg = ipc_merge({16'h0, s.altTable, 12'h0, s.polarity}, wrVal, s.wStrb);
          next_s.altTable = mrg[`IPC_BIT_ALT];
          next_s.polarity = mrg[`IPC_NEXT-1:0];
        end
        `IPC_OFF_FLAG: begin
          mrg = ipc_merge('0, wrVal, s.wStrb);
          next_s.flags = s.flags & ~mrg[`IPC_NSRC-1:0];
        end
        `IPC_OFF_ENA: begin
          mrg = ipc_merge({24'h0, s.enable}, wrVal, s.wStrb);
          next_s.enable = mrg[`IPC_NSRC-1:0];
        end
        `IPC_OFF_PRIO: begin
          mrg = ipc_merge({8'h0, s.prio}, wrVal, s.wStrb);
          next_s.prio = mrg[3*`IPC_NSRC-1:0];
        end
        `IPC_OFF_CPU: begin
          mrg = ipc_merge({23'h0, s.cpuPri, 5'h0}, wrVal, s.wStrb);
          next_s.cpuPri = mrg[`IPC_CPU_LSB+:4];
        end
        `IPC_OFF_TDIS: begin
          mrg = ipc_merge({18'h0, s.tdCount}, wrVal, s.wStrb);
          next_s.tdCount = mrg[`IPC_TD_W-1:0];
        end
        `IPC_OFF_ICLR: next_s.intStatus = s.intStatus & ~wrVal[`IPC_NEVT-1:0];
        `IPC_OFF_IENA: begin
          mrg = ipc_merge('0, wrVal, s.wStrb);
          next_s.intEnable = mrg[`IPC_NEVT-1:0];
        end
        default: next_s.flags = next_s.flags;
      endcase
    end
    // Hardware sets win over a software clear in the same cycle
    next_s.flags = next_s.flags | srcSet;
    next_s.trapFlags = next_s.trapFlags | trapReq;
    evt[`IPC_EVT_TRAP] = |trapReq;
    // Core handshake: entry pushes context, return pops it
    if (ackTake) begin
      // Saved low status carries the old low priority bits in its top three bits
      next_s.stack[s.depth[3:0]] = {s.cpuPri[3], pcIn, s.cpuPri[2:0], statusLowIn[`IPC_CPU_LSB-1:0]};
      next_s.cpuPri = s.reqLevel;
      // Deeper nesting than the stack holds overwrites the bottom entry, stack[0], and depth stays at 16
      if (s.depth != 5'(`IPC_DEPTH)) begin
        next_s.depth = s.depth + 1'b1;
      end
      evt[`IPC_EVT_ACCEPT] = 1'b1;
    end else if (retTake) begin
      next_s.depth = s.depth - 1'b1;
      next_s.retPc = s.stack[4'(s.depth - 1'b1)][31:8];
      next_s.retSrl = s.stack[4'(s.depth - 1'b1)][7:0];
      next_s.cpuPri = {s.stack[4'(s.depth - 1'b1)][32], s.stack[4'(s.depth - 1'b1)][7:5]};
      evt[`IPC_EVT_RETURN] = 1'b1;
    end
    next_s.intStatus = next_s.intStatus | evt;
    // Offer is dropped for a cycle after an acknowledge or a return so it is recomputed
    next_s.reqValid = candOk && !irqAck && !returnFromInterrupt;
    next_s.reqTrap = candTrap;
    next_s.reqNum = candNum;
    next_s.reqLevel = candLevel;
    next_s.vector = (s.altTable ? `IPC_ALT_BASE : `IPC_STD_BASE) + {10'h0, candNum, 1'b0};
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s <= '0;
      s.prio <= `IPC_PRIO_RST;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign axiRsp.awready = ~s.awHeld & ~s.bvalid;
  assign axiRsp.wready = ~s.wHeld & ~s.bvalid;
  assign axiRsp.bvalid = s.bvalid;
  assign axiRsp.bresp = s.bresp;
  assign axiRsp.arready = ~s.rvalid;
  assign axiRsp.rvalid = s.rvalid;
  assign axiRsp.rdata = s.rdata;
  assign axiRsp.rresp = s.rresp;
  assign irqReq = s.reqValid;
  assign irqVector = s.vector;
  assign irqLevel = s.reqLevel;
  assign retPc = s.retPc;
  assign retStatusLow = s.retSrl;
  assign cpuPriority = s.cpuPri;
  assign intr = |(s.intStatus & s.intEnable);

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  prio_reset_a: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(reset) |-> s.prio == `IPC_PRIO_RST)
    else $error("priorities not at level 4 after reset");

  vector_table_a: assert property (@(posedge sys_clk) disable iff (reset)
    s.reqValid |-> s.vector == (($past(s.altTable) ? `IPC_ALT_BASE : `IPC_STD_BASE) + {10'h0, s.reqNum, 1'b0}))
    else $error("vector not from selected table");

  user_mask_a: assert property (@(posedge sys_clk) disable iff (reset)
    s.reqValid && !s.reqTrap |-> s.reqLevel > $past(s.cpuPri) && s.reqLevel <= `IPC_USER_MAX)
    else $error("masked user level offered");

  timed_mask_a: assert property (@(posedge sys_clk) disable iff (reset)
    $past(tdActive) && s.reqValid && !s.reqTrap |-> s.reqLevel == {1'b0, `IPC_TD_TOP})
    else $error("level below 7 offered during timed disable");

  nest_block_a: assert property (@(posedge sys_clk) disable iff (reset)
    $past(s.nestDis && s.depth != '0) && s.reqValid |-> s.reqTrap)
    else $error("user interrupt nested while nesting disabled");

  trap_taken_a: assert property (@(posedge sys_clk) disable iff (reset)
    |s.trapFlags && s.cpuPri < `IPC_TRAP_BASE && !irqAck && !returnFromInterrupt |=> s.reqValid && s.reqTrap)
    else $error("pending trap not offered");

  flag_sticky_a: assert property (@(posedge sys_clk) disable iff (reset)
    !(wrEn && s.awAddr == `IPC_OFF_FLAG) |=> (s.flags & $past(s.flags)) == $past(s.flags))
    else $error("request flag lost without software clear");

  return_restore_a: assert property (@(posedge sys_clk) disable iff (reset)
    ackTake && !s.reqTrap ##1 !irqAck [*2] ##1 retTake && s.depth == $past(s.depth, 3) + 1'b1
    |=> s.cpuPri == $past(s.cpuPri, 4) && s.retPc == $past(pcIn, 4))
    else $error("return did not restore saved context");

  td_status_a: assert property (@(posedge sys_clk) disable iff (reset)
    rdEn && axiReq.araddr == `IPC_OFF_EVC |=> s.rdata[`IPC_BIT_TDACT] == $past(tdActive))
    else $error("timed disable status bit wrong");
endmodule : ipc_controller

// [bench/ipc_core_model.sv]
// Core-side partner: takes offered interrupts and issues returns
`timescale 1ns/1ps
module ipc_core_model (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic irqReq,
  input wire logic slow,
  input wire logic retRequest,
  output logic irqAck,
  output logic returnFromInterrupt
);
  logic [1:0] waitCount;
  // ----------------------------------------
  // Acceptance and return
  // ----------------------------------------
  // Slow mode lets the offer stand a few cycles before it is taken
  always @(posedge sys_clk) begin
    if (reset) begin
      irqAck <= 1'b0;
      returnFromInterrupt <= 1'b0;
      waitCount <= 2'h0;
    end else begin
      returnFromInterrupt <= retRequest;
      if (irqReq && !irqAck && (!slow || waitCount == 2'h3)) begin
        irqAck <= 1'b1;
        waitCount <= 2'h0;
      end else begin
        irqAck <= 1'b0;
        waitCount <= irqReq ? waitCount + 2'h1 : 2'h0;
      end
    end
  end
endmodule : ipc_core_model

// [bench/test_interrupt_priority_controller.sv]
// Self-checking bench for the interrupt controller
`timescale 1ns/1ps
`include "ipc_consts.svh"
module test_interrupt_priority_controller;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  ipc_pkg::ipc_axi_req_s axiReq = '0;
  ipc_pkg::ipc_axi_rsp_s axiRsp;
  logic [`IPC_NEXT-1:0] extPin = '0;
  logic [`IPC_NPER-1:0] periphReq = '0;
  logic [`IPC_NTRAP-1:0] trapReq = '0;
  logic instrTick = 1'b0;
  logic irqReq, irqAck, returnFromInterrupt, intr;
  logic [15:0] irqVector;
  logic [3:0] irqLevel, cpuPriority, ackLevel;
  logic [23:0] pcIn = 24'h000000;
  logic [23:0] retPc;
  logic [7:0] statusLowIn = 8'h00;
  logic [7:0] retStatusLow;
  logic slow = 1'b0, retRequest = 1'b0, altOn = 1'b1, retDue = 1'b0, ackDue = 1'b0;
  logic [35:0] ctxQ[$];
  logic [35:0] retCtx;
  logic [19:0] irqQ[$];
  logic [33:0] busQ[$];
  int mismatches = 0, checkCount = 0, seed = 32'h7C2AF03E;

  ipc_controller DUT (.sys_clk(sys_clk), .reset(reset), .axiReq(axiReq), .axiRsp(axiRsp), .extPin(extPin),
    .periphReq(periphReq), .trapReq(trapReq), .instrTick(instrTick), .irqReq(irqReq), .irqVector(irqVector),
    .irqLevel(irqLevel), .irqAck(irqAck), .pcIn(pcIn), .statusLowIn(statusLowIn),
    .returnFromInterrupt(returnFromInterrupt), .retPc(retPc), .retStatusLow(retStatusLow),
    .cpuPriority(cpuPriority), .intr(intr));
  ipc_core_model core (.sys_clk(sys_clk), .reset(reset), .irqReq(irqReq), .slow(slow), .retRequest(retRequest),
    .irqAck(irqAck), .returnFromInterrupt(returnFromInterrupt));

  always #12.5 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [35:0] exp, input logic [35:0] got);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic conclude();
    $display("Counts: %0d checks, %0d mismatches", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic giveUp();
    mismatches++;
    $display("BAD wait expected handshake seen none");
    conclude();
  endtask : giveUp

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n;
    n = 0;
    @(posedge sys_clk);
    busQ.push_back({r, 32'h0});
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.wstrb <= 4'hF;
    axiReq.bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (axiReq.awvalid && axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiReq.wvalid && axiRsp.wready) axiReq.wvalid <= 1'b0;
    end while (!axiRsp.bvalid && n < 200);
    if (n >= 200) giveUp();
    axiReq.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int n;
    n = 0;
    @(posedge sys_clk);
    busQ.push_back({r, d});
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (axiReq.arvalid && axiRsp.arready) axiReq.arvalid <= 1'b0;
    end while (!axiRsp.rvalid && n < 200);
    if (n >= 200) giveUp();
    axiReq.rready <= 1'b0;
  endtask : rd

  function automatic void offer(input logic [3:0] lvl, input logic [4:0] n);
    irqQ.push_back({lvl, (altOn ? 16'h0104 : 16'h0004) + {10'h0, n, 1'b0}});
  endfunction : offer

  // Waits until every noted offer has been taken by the core
  task automatic waitAck();
    int n;
    n = 0;
    while (irqQ.size() != 0 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 300) giveUp();
  endtask : waitAck

  task automatic pulse(input logic [4:0] p, input logic [3:0] t);
    @(posedge sys_clk);
    periphReq <= p;
    trapReq <= t;
    @(posedge sys_clk);
    periphReq <= 5'h00;
    trapReq <= 4'h0;
  endtask : pulse

  task automatic ret();
    @(posedge sys_clk);
    retRequest <= 1'b1;
    @(posedge sys_clk);
    retRequest <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : ret

  // ----------------------------------------
  // Random core context and instruction ticks
  // ----------------------------------------
  always @(posedge sys_clk) begin
    logic [31:0] r;
    r = $random(seed);
    instrTick <= r[0];
    pcIn <= r[31:8];
    statusLowIn <= r[7:0];
  end

  // ----------------------------------------
  // Monitor: compares offers and bus responses against the oldest note, returns against the newest saved context
  // ----------------------------------------
  always @(posedge sys_clk) begin
    logic [33:0] e;
    if (ackDue) check("cpuPriority", {32'h0, ackLevel}, {32'h0, cpuPriority});
    if (retDue) begin
      check("retPc", {12'h0, retCtx[31:8]}, {12'h0, retPc});
      check("retStatusLow", {31'h0, retCtx[4:0]}, {31'h0, retStatusLow[4:0]});
      check("cpuPriority", {32'h0, retCtx[35:32]}, {32'h0, cpuPriority});
    end
    ackDue = 1'b0;
    retDue = 1'b0;
    if (irqReq && irqAck) begin
      ctxQ.push_back({cpuPriority, pcIn, statusLowIn});
      ackLevel = irqLevel;
      ackDue = 1'b1;
      if (irqQ.size() == 0) begin
        mismatches++;
        $display("BAD offer expected none seen %h", {irqLevel, irqVector});
      end else begin
        check("offer", {16'h0, irqQ.pop_front()}, {16'h0, irqLevel, irqVector});
      end
    end
    if (returnFromInterrupt && ctxQ.size() > 0) begin
      retCtx = ctxQ.pop_back();
      retDue = 1'b1;
    end
    if (axiRsp.bvalid && axiReq.bready) begin
      e = busQ.pop_front();
      check("bresp", {34'h0, e[33:32]}, {34'h0, axiRsp.bresp});
    end
    if (axiRsp.rvalid && axiReq.rready) begin
      e = busQ.pop_front();
      check("rdata", {2'h0, e}, {2'h0, axiRsp.rresp, axiRsp.rdata});
    end
  end

  initial begin
    repeat (80000) @(posedge sys_clk);
    giveUp();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    rd(8'h10, 32'h0092_4924);
    rd(8'h14, 32'h0);
    rd(8'h80, 32'h0, 2'h2);
    wr(8'h80, 32'h0, 2'h2);
    wr(8'h04, 32'hFFFF_FFFF);
    rd(8'h04, 32'h0000_8007);
    $display("Test registers finished");
    wr(8'h08, 32'hFF);
    wr(8'h0C, 32'h08);
    slow <= 1'b1;
    offer(4'h4, 5'd11);
    pulse(5'h01, 4'h0);
    waitAck();
    rd(8'h14, 32'h80);
    altOn = 1'b0;
    wr(8'h04, 32'h0);
    offer(4'h4, 5'd11);
    ret();
    waitAck();
    wr(8'h08, 32'h08);
    ret();
    slow <= 1'b0;
    pulse(5'h02, 4'h0);
    repeat (10) @(posedge sys_clk);
    wr(8'h08, 32'h10);
    $display("Test offer finished");
    for (int i = 0; i < 3; i++) begin
      for (int p = 0; p < 2; p++) begin
        wr(8'h0C, 32'h0);
        extPin[i] <= p[0];
        repeat (4) @(posedge sys_clk);
        wr(8'h04, 32'(p) << i);
        wr(8'h08, 32'hFF);
        wr(8'h0C, 32'h1 << i);
        offer(4'h4, 5'(8 + i));
        extPin[i] <= !p[0];
        waitAck();
        wr(8'h08, 32'h1 << i);
        ret();
        extPin[i] <= p[0];
        repeat (8) @(posedge sys_clk);
      end
    end
    $display("Test pins finished");
    wr(8'h14, 32'hE0);
    wr(8'h0C, 32'h08);
    pulse(5'h01, 4'h0);
    repeat (12) @(posedge sys_clk);
    offer(4'h8, 5'd0);
    pulse(5'h00, 4'h1);
    waitAck();
    rd(8'h00, 32'h1);
    wr(8'h00, 32'h0);
    ret();
    offer(4'h4, 5'd11);
    wr(8'h14, 32'h0);
    waitAck();
    wr(8'h08, 32'h08);
    ret();
    $display("Test masking finished");
    wr(8'h10, 32'h0092_4E24);
    wr(8'h0C, 32'h18);
    wr(8'h18, 32'd20);
    rd(8'h04, 32'h4004);
    pulse(5'h02, 4'h0);
    repeat (6) @(posedge sys_clk);
    offer(4'h7, 5'd11);
    pulse(5'h01, 4'h0);
    waitAck();
    wr(8'h08, 32'h08);
    offer(4'h4, 5'd12);
    ret();
    waitAck();
    rd(8'h04, 32'h4);
    wr(8'h08, 32'h10);
    ret();
    $display("Test timed disable finished");
    wr(8'h10, 32'h0092_4924);
    wr(8'h0C, 32'hF8);
    offer(4'h4, 5'd12);
    pulse(5'h1A, 4'h0);
    waitAck();
    wr(8'h08, 32'h10);
    offer(4'h4, 5'd14);
    ret();
    waitAck();
    wr(8'h08, 32'h40);
    offer(4'h4, 5'd15);
    ret();
    waitAck();
    wr(8'h08, 32'h80);
    ret();
    $display("Test ties finished");
    wr(8'h10, 32'h0093_4924);
    wr(8'h0C, 32'h28);
    wr(8'h00, 32'h8000);
    offer(4'h4, 5'd11);
    pulse(5'h01, 4'h0);
    waitAck();
    pulse(5'h04, 4'h0);
    repeat (10) @(posedge sys_clk);
    offer(4'h6, 5'd13);
    wr(8'h00, 32'h0);
    waitAck();
    wr(8'h08, 32'h28);
    ret();
    ret();
    $display("Test nesting finished");
    rd(8'h1C, 32'h7);
    check("intr", 36'h0, {35'h0, intr});
    wr(8'h24, 32'h7);
    @(posedge sys_clk);
    check("intr", 36'h1, {35'h0, intr});
    wr(8'h20, 32'h7);
    rd(8'h1C, 32'h0);
    @(posedge sys_clk);
    check("intr", 36'h0, {35'h0, intr});
    $display("Test interrupt finished");
    conclude();
  end
endmodule : test_interrupt_priority_controller
